// File: logic/blink_pkg.sv
// Constants and types shared by the pixel blink unit.
package blink_pkg;

	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int PIX_W = 24;
	localparam int RATE_W = 8;
	localparam int MODE_W = 4;
	localparam int FMT_W = 4;

	// Register byte addresses inside the block's window.
	localparam logic [ADDR_W-1:0] OFF_FRAME_TOGGLE_PERIOD = 32'h8003_0040;
	localparam logic [ADDR_W-1:0] OFF_LUT_ADDRESS_MODIFIER = 32'h8003_0044;
	localparam logic [ADDR_W-1:0] OFF_BLINK_MATCH_VALUE = 32'h8003_0048;
	localparam logic [ADDR_W-1:0] OFF_COMPARE_BIT_EXCLUDE = 32'h8003_004C;
	localparam logic [ADDR_W-1:0] OFF_SUBSTITUTE_COLOR = 32'h8003_0050;
	localparam logic [ADDR_W-1:0] OFF_PIXEL_FORMAT_CONTROL = 32'h8003_0054;

	localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;
	localparam logic [DATA_W-1:0] UNMAPPED_WORD = 32'hDEAD_0BAD;
	localparam logic [RATE_W-1:0] RATE_FULL = 8'hFF;
	localparam logic [RATE_W-1:0] RATE_ONE = 8'h01;

	// Fields of pixel_format_control.
	localparam int MODE_LSB = 0;
	localparam int FMT_LSB = 4;

	localparam logic [FMT_W-1:0] FMT_888 = 4'h4;
	localparam logic [FMT_W-1:0] FMT_565 = 4'h5;
	localparam logic [FMT_W-1:0] FMT_555_MASK = 4'h6;

	typedef enum logic [MODE_W-1:0] {
		MODE_OFF = 4'b0000,
		MODE_AND = 4'b0001,
		MODE_OR = 4'b0010,
		MODE_XOR = 4'b0011,
		MODE_BKG = 4'b0100,
		MODE_OFS_SINGLE = 4'b0101,
		MODE_OFS_CHAN = 4'b0110,
		MODE_DIM_SINGLE = 4'b1100,
		MODE_BRT_SINGLE = 4'b1101,
		MODE_DIM_CHAN = 4'b1110,
		MODE_BRT_CHAN = 4'b1111
	} blink_mode_type;

	typedef enum logic [1:0] {
		PH_UNMASKED = 2'b00,
		PH_MASKED = 2'b01
	} phase_type;

endpackage

// File: logic/pixel_skid.sv
// Two-entry buffer between the blink datapath and the colour look-up table.
`timescale 1ns/1ps
module pixel_skid
	import blink_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic in_valid_in,
	input wire logic [PIX_W-1:0] in_data_in,
	output logic in_ready_out,
	output logic out_valid_out,
	output logic [PIX_W-1:0] out_data_out,
	input wire logic out_ready_in
);

	typedef struct packed {
		logic [1:0][PIX_W-1:0] mem;
		logic [1:0] count;
		logic rd;
		logic wr;
	} skid_state_type;

	skid_state_type s_q;
	skid_state_type s_d;
	logic push;
	logic pop;

	always_comb begin
		s_d = s_q;
		pop = s_q.count != 2'd0 && out_ready_in;
		push = in_valid_in && s_q.count != 2'd2;
		if (push) begin
			s_d.mem[s_q.wr] = in_data_in;
			s_d.wr = ~s_q.wr;
		end
		if (pop) begin
			s_d.rd = ~s_q.rd;
		end
		s_d.count = s_q.count + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Full and empty come straight from the stored count.
	assign in_ready_out = s_q.count != 2'd2;
	assign out_valid_out = s_q.count != 2'd0;
	assign out_data_out = s_q.mem[s_q.rd];

endmodule

// File: logic/pixel_blink_unit.sv
// Pixel blink unit: frame counter, blink classifier, address modifier and register slave.
//
// What this block does
// - Blink rate register sets how many frames pass between masked and unmasked phases.
// - Full blink period is two times pixel period, line, frame and 255 minus rate.
// - Modes one to three AND, OR or XOR the pixel with the modifier mask.
// - In the masked phase, in modes one to three, blink pixels are redirected to the modified table address.
// - Pixel is masked first, then compared with the match value to classify it.
// - Exclude bit one drops that bit from the compare; zero keeps it.
// - Background mode replaces blink pixels with the 24-bit substitute colour.
// - Offset modes add the substitute value in 888, 565 or 555 format.
// - Reserved register bits read unspecified; here they read zero.
// - Mode code zero disables, one AND, two OR, three XOR.
// - Code four background, five single offset, six per-channel, upper codes dim or brighten.
`timescale 1ns/1ps
module pixel_blink_unit
	import blink_pkg::*;
(
	input wire logic CLK_SYS_IN,
	input wire logic RESET_IN,
	input wire logic [ADDR_W-1:0] AVS_ADDRESS_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic [DATA_W-1:0] AVS_WRITEDATA_IN,
	input wire logic [3:0] AVS_BYTEENABLE_IN,
	output logic [DATA_W-1:0] AVS_READDATA_OUT,
	output logic AVS_WAITREQUEST_OUT,
	input wire logic FRAME_START_IN,
	input wire logic PIX_VALID_IN,
	input wire logic [PIX_W-1:0] PIX_DATA_IN,
	output logic PIX_READY_OUT,
	output logic LUT_VALID_OUT,
	output logic [PIX_W-1:0] LUT_DATA_OUT,
	input wire logic LUT_READY_IN,
	output logic BLINK_PHASE_OUT
);

	typedef struct packed {
		logic [RATE_W-1:0] rate;
		logic [PIX_W-1:0] modifier;
		logic [PIX_W-1:0] match;
		logic [PIX_W-1:0] exclude;
		logic [PIX_W-1:0] subst;
		logic [FMT_W+MODE_W-1:0] fmt_ctrl;
		logic [RATE_W-1:0] frame_cnt;
		phase_type phase;
		logic ack;
		logic [DATA_W-1:0] rdata;
		logic pix_valid;
		logic [PIX_W-1:0] pix;
	} unit_state_type;

	unit_state_type s_q;
	unit_state_type s_d;
	logic skid_ready;
	logic skid_valid;
	logic [PIX_W-1:0] skid_data;
	logic req;
	logic [DATA_W-1:0] wmask;
	blink_mode_type mode;
	logic [FMT_W-1:0] fmt;
	logic [PIX_W-1:0] modified;
	logic [PIX_W-1:0] result;
	logic is_blink;
	logic frame_tick;
	logic advance;

	// Merge write data into an old register value under the byte enables.
	function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
		input logic [DATA_W-1:0] new_v, input logic [DATA_W-1:0] m);
		merge = (old_v & ~m) | (new_v & m);
	endfunction

	// Add or subtract per channel with saturation, lane widths from the colour format.
	function automatic logic [PIX_W-1:0] chan_add(input logic [PIX_W-1:0] p,
		input logic [PIX_W-1:0] o, input logic [FMT_W-1:0] f, input logic sub,
		input logic single);
		logic [8:0] t;
		logic [PIX_W-1:0] r;
		logic [PIX_W-1:0] oo;
		int w;
		int base;
		int k;
		r = p;
		oo = o;
		base = 0;
		for (k = 0; k < 3; k++) begin
			if (f == FMT_565) begin
				w = (k == 1) ? 6 : 5;
			end else if ((f & FMT_555_MASK) == FMT_555_MASK) begin
				w = 5;
			end else begin
				w = 8;
			end
			if (single) begin
				oo[base +: 8] = o[7:0];
			end
			t = {1'b0, p[base +: 8] & 8'((1 << w) - 1)};
			if (sub) begin
				t = t - {1'b0, oo[base +: 8] & 8'((1 << w) - 1)};
				if (t[8]) begin
					t = 9'h000;
				end
			end else begin
				t = t + {1'b0, oo[base +: 8] & 8'((1 << w) - 1)};
				if (t > 9'((1 << w) - 1)) begin
					t = 9'((1 << w) - 1);
				end
			end
			r[base +: 8] = (p[base +: 8] & ~8'((1 << w) - 1)) | t[7:0];
			base = base + w;
		end
		chan_add = r;
	endfunction

	pixel_skid u_skid (
		.clk_in(CLK_SYS_IN),
		.reset_in(RESET_IN),
		.in_valid_in(s_q.pix_valid),
		.in_data_in(s_q.pix),
		.in_ready_out(skid_ready),
		.out_valid_out(skid_valid),
		.out_data_out(skid_data),
		.out_ready_in(LUT_READY_IN)
	);

	always_comb begin
		s_d = s_q;
		req = (AVS_READ_IN || AVS_WRITE_IN) && !s_q.ack;
		wmask = {{8{AVS_BYTEENABLE_IN[3]}}, {8{AVS_BYTEENABLE_IN[2]}},
			{8{AVS_BYTEENABLE_IN[1]}}, {8{AVS_BYTEENABLE_IN[0]}}};
		mode = blink_mode_type'(s_q.fmt_ctrl[MODE_LSB +: MODE_W]);
		fmt = s_q.fmt_ctrl[FMT_LSB +: FMT_W];

		// One wait state per access: the answer comes on the second edge.
		s_d.ack = req;
		if (req && AVS_WRITE_IN) begin
			if (AVS_ADDRESS_IN == OFF_FRAME_TOGGLE_PERIOD) begin
				s_d.rate = RATE_W'(merge(DATA_W'(s_q.rate), AVS_WRITEDATA_IN, wmask));
			end else if (AVS_ADDRESS_IN == OFF_LUT_ADDRESS_MODIFIER) begin
				s_d.modifier = PIX_W'(merge(DATA_W'(s_q.modifier), AVS_WRITEDATA_IN, wmask));
			end else if (AVS_ADDRESS_IN == OFF_BLINK_MATCH_VALUE) begin
				s_d.match = PIX_W'(merge(DATA_W'(s_q.match), AVS_WRITEDATA_IN, wmask));
			end else if (AVS_ADDRESS_IN == OFF_COMPARE_BIT_EXCLUDE) begin
				s_d.exclude = PIX_W'(merge(DATA_W'(s_q.exclude), AVS_WRITEDATA_IN, wmask));
			end else if (AVS_ADDRESS_IN == OFF_SUBSTITUTE_COLOR) begin
				s_d.subst = PIX_W'(merge(DATA_W'(s_q.subst), AVS_WRITEDATA_IN, wmask));
			end else if (AVS_ADDRESS_IN == OFF_PIXEL_FORMAT_CONTROL) begin
				s_d.fmt_ctrl = (FMT_W+MODE_W)'(merge(DATA_W'(s_q.fmt_ctrl),
					AVS_WRITEDATA_IN, wmask));
			end
		end
		// Reserved bits read as zero through the zero extension below.
		if (req && AVS_READ_IN) begin
			if (AVS_ADDRESS_IN == OFF_FRAME_TOGGLE_PERIOD) begin
				s_d.rdata = DATA_W'(s_q.rate);
			end else if (AVS_ADDRESS_IN == OFF_LUT_ADDRESS_MODIFIER) begin
				s_d.rdata = DATA_W'(s_q.modifier);
			end else if (AVS_ADDRESS_IN == OFF_BLINK_MATCH_VALUE) begin
				s_d.rdata = DATA_W'(s_q.match);
			end else if (AVS_ADDRESS_IN == OFF_COMPARE_BIT_EXCLUDE) begin
				s_d.rdata = DATA_W'(s_q.exclude);
			end else if (AVS_ADDRESS_IN == OFF_SUBSTITUTE_COLOR) begin
				s_d.rdata = DATA_W'(s_q.subst);
			end else if (AVS_ADDRESS_IN == OFF_PIXEL_FORMAT_CONTROL) begin
				s_d.rdata = {{(DATA_W-FMT_W-MODE_W-1){1'b0}}, s_q.phase == PH_MASKED,
					s_q.fmt_ctrl};
			end else begin
				s_d.rdata = UNMAPPED_WORD;
			end
		end

		// The phase toggles after 255 - rate frames, giving the doubled full period.
		frame_tick = FRAME_START_IN;
		advance = 1'b0;
		if (frame_tick) begin
			if (s_q.frame_cnt + RATE_ONE >= RATE_FULL - s_q.rate) begin
				s_d.frame_cnt = '0;
				advance = 1'b1;
			end else begin
				s_d.frame_cnt = s_q.frame_cnt + RATE_ONE;
			end
		end
		if (advance) begin
			s_d.phase = (s_q.phase == PH_MASKED) ? PH_UNMASKED : PH_MASKED;
		end

		// Classify: modify first, then compare under the exclude bits.
		case (mode)
			MODE_AND: modified = PIX_DATA_IN & s_q.modifier;
			MODE_OR: modified = PIX_DATA_IN | s_q.modifier;
			MODE_XOR: modified = PIX_DATA_IN ^ s_q.modifier;
			default: modified = PIX_DATA_IN & s_q.modifier;
		endcase
		is_blink = ((modified ^ s_q.match) & ~s_q.exclude) == '0;

		result = PIX_DATA_IN;
		if (is_blink && s_q.phase == PH_MASKED) begin
			case (mode)
				MODE_AND: result = modified;
				MODE_OR: result = modified;
				MODE_XOR: result = modified;
				MODE_BKG: result = s_q.subst;
				MODE_OFS_SINGLE: result = chan_add(PIX_DATA_IN, s_q.subst, fmt, 1'b0, 1'b1);
				MODE_OFS_CHAN: result = chan_add(PIX_DATA_IN, s_q.subst, fmt, 1'b0, 1'b0);
				MODE_DIM_SINGLE: result = chan_add(PIX_DATA_IN, s_q.subst, fmt, 1'b1, 1'b1);
				MODE_BRT_SINGLE: result = chan_add(PIX_DATA_IN, s_q.subst, fmt, 1'b0, 1'b1);
				MODE_DIM_CHAN: result = chan_add(PIX_DATA_IN, s_q.subst, fmt, 1'b1, 1'b0);
				MODE_BRT_CHAN: result = chan_add(PIX_DATA_IN, s_q.subst, fmt, 1'b0, 1'b0);
				default: result = PIX_DATA_IN;
			endcase
		end

		// The pipeline stage advances when the buffer can take its word or when the stage holds no word.
		if (skid_ready || !s_q.pix_valid) begin
			s_d.pix_valid = PIX_VALID_IN;
			if (PIX_VALID_IN) begin
				s_d.pix = result;
			end
		end
	end

	always_ff @(posedge CLK_SYS_IN) begin
		if (RESET_IN) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	always_comb begin
		PIX_READY_OUT = skid_ready || !s_q.pix_valid;
	end

	assign AVS_READDATA_OUT = s_q.rdata;
	assign AVS_WAITREQUEST_OUT = !s_q.ack;
	assign LUT_VALID_OUT = skid_valid;
	assign LUT_DATA_OUT = skid_data;
	assign BLINK_PHASE_OUT = s_q.phase == PH_MASKED;

endmodule

// File: verification/blink_checker_asserts.sv
// Port-level assertions for the pixel blink unit.
`timescale 1ns/1ps
module blink_checker
	import blink_pkg::*;
(
	input wire logic CLK_SYS_IN,
	input wire logic RESET_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic [DATA_W-1:0] AVS_READDATA_OUT,
	input wire logic AVS_WAITREQUEST_OUT,
	input wire logic FRAME_START_IN,
	input wire logic PIX_VALID_IN,
	input wire logic PIX_READY_OUT,
	input wire logic LUT_VALID_OUT,
	input wire logic [PIX_W-1:0] LUT_DATA_OUT,
	input wire logic LUT_READY_IN,
	input wire logic BLINK_PHASE_OUT
);
	default clocking @(posedge CLK_SYS_IN); endclocking
	default disable iff (RESET_IN);
	sequence bus_req_s;
		(AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT;
	endsequence
	sequence pix_take_s;
		PIX_VALID_IN && PIX_READY_OUT;
	endsequence
	bus_answer_a: assert property (bus_req_s |=> !AVS_WAITREQUEST_OUT)
		else $error("bus request not answered after one wait");
	wait_pulse_a: assert property (!AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
		else $error("waitrequest low for more than one cycle");
	wait_cause_a: assert property ($fell(AVS_WAITREQUEST_OUT)
		|-> $past(AVS_READ_IN) || $past(AVS_WRITE_IN)) else $error("answer without request");
	reset_state_a: assert property (disable iff (1'b0) RESET_IN |=> AVS_WAITREQUEST_OUT
		&& !LUT_VALID_OUT && !BLINK_PHASE_OUT) else $error("state not cleared by reset");
	reset_rdata_a: assert property (disable iff (1'b0) RESET_IN |=> AVS_READDATA_OUT == '0)
		else $error("read data not cleared by reset");
	phase_frame_a: assert property ($changed(BLINK_PHASE_OUT) && !$past(RESET_IN)
		|-> $past(FRAME_START_IN) || $past(FRAME_START_IN, 2)) else $error("phase moved mid frame");
	lut_hold_a: assert property (LUT_VALID_OUT && !LUT_READY_IN |=> LUT_VALID_OUT
		&& $stable(LUT_DATA_OUT)) else $error("stalled pixel dropped or changed");
	pix_flow_a: assert property (pix_take_s |-> ##[1:3] LUT_VALID_OUT)
		else $error("accepted pixel did not reach the table");
endmodule

bind pixel_blink_unit blink_checker u_blink_checker (.CLK_SYS_IN, .RESET_IN, .AVS_READ_IN,
	.AVS_WRITE_IN, .AVS_READDATA_OUT, .AVS_WAITREQUEST_OUT, .FRAME_START_IN, .PIX_VALID_IN,
	.PIX_READY_OUT, .LUT_VALID_OUT, .LUT_DATA_OUT, .LUT_READY_IN, .BLINK_PHASE_OUT);

// File: verification/lut_sink.sv
// Colour look-up table model that takes pixels with optional random stalls.
`timescale 1ns/1ps
module lut_sink
(
	input wire logic clk_in,
	input wire logic stall_in,
	output logic ready_out = 1'b0
);
	// Random back-pressure fills the two-entry buffer so its full path is exercised.
	always @(posedge clk_in) begin
		ready_out <= stall_in ? 1'($urandom_range(1)) : 1'b1;
	end
endmodule

// File: verification/tb_top.sv
// Self-checking bench of the pixel blink unit.
`timescale 1ns/1ps
module tb_top
	import blink_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic fs = 1'b0;
	logic pv = 1'b0;
	logic stall = 1'b0;
	logic [3:0] be = 4'hF;
	logic [DATA_W-1:0] adr = '0;
	logic [DATA_W-1:0] wdat = '0;
	logic [PIX_W-1:0] pd = '0;
	logic [DATA_W-1:0] rdat;
	logic wq, prdy, lv, lr, ph;
	logic [PIX_W-1:0] ld, mk, sb, r;
	logic [DATA_W-1:0] rq[$];
	logic [PIX_W-1:0] pq[$];
	int n_fail = 0;
	int compares = 0;
	int i, n;
	logic [3:0] modes [12] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hC, 4'hD, 4'hE, 4'hF,
		4'h7, 4'h0};
	pixel_blink_unit u_pixel_blink_unit (.CLK_SYS_IN(clk), .RESET_IN(rst), .AVS_ADDRESS_IN(adr),
		.AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdat), .AVS_BYTEENABLE_IN(be),
		.AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wq), .FRAME_START_IN(fs), .PIX_VALID_IN(pv),
		.PIX_DATA_IN(pd), .PIX_READY_OUT(prdy), .LUT_VALID_OUT(lv), .LUT_DATA_OUT(ld),
		.LUT_READY_IN(lr), .BLINK_PHASE_OUT(ph));
	lut_sink u_lut_sink (.clk_in(clk), .stall_in(stall), .ready_out(lr));
	initial forever #4 clk = ~clk;
	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic hang;
		n_fail++;
		results();
	endtask
	// Ready levels are looked at mid-cycle, so the transfer edge is the one that follows.
	task automatic await(input bit pixel);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (!(pixel ? prdy : !wq) && n < 50);
		if (!(pixel ? prdy : !wq)) hang();
		@(posedge clk);
	endtask
	task automatic bus(input logic w, input logic [DATA_W-1:0] a, d, e);
		if (!w) rq.push_back(e);
		adr <= a;
		wdat <= d;
		rd <= !w;
		wr <= w;
		await(1'b0);
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic pix(input logic [PIX_W-1:0] d, e);
		pv <= 1'b1;
		pd <= d;
		await(1'b1);
		pq.push_back(e);
	endtask
	task automatic frame;
		fs <= 1'b1;
		@(posedge clk);
		fs <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	function automatic logic [PIX_W-1:0] xf(input logic [3:0] m, input logic [PIX_W-1:0] p);
		logic [PIX_W-1:0] o;
		int v;
		o = p;
		case (m)
			4'h1: o = p & mk;
			4'h2: o = p | mk;
			4'h3: o = p ^ mk;
			4'h4: o = sb;
			4'h5, 4'h6, 4'hC, 4'hD, 4'hE, 4'hF: begin
				for (int c = 0; c < 3; c++) begin
					v = (m inside {4'h5, 4'hC, 4'hD}) ? sb[7:0] : sb[8*c+:8];
					v = (m inside {4'hC, 4'hE}) ? p[8*c+:8] - v : p[8*c+:8] + v;
					o[8*c+:8] = v < 0 ? 8'h00 : v > 255 ? 8'hFF : v[7:0];
				end
			end
			default: o = p;
		endcase
		return o;
	endfunction
	always @(negedge clk) begin
		if (lv && lr) check(ld, pq.size() > 0 ? pq.pop_front() : 'x);
		if (rd && !wq) check(rdat, rq.size() > 0 ? rq.pop_front() : 'x);
	end
	initial begin
		void'($urandom(32'h2fd6_0691));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (i = 0; i < 5; i++) begin
			bus(1'b0, OFF_FRAME_TOGGLE_PERIOD + 4 * i, '0, RESET_WORD);
			bus(1'b1, OFF_FRAME_TOGGLE_PERIOD + 4 * i, '1, '0);
			bus(1'b0, OFF_FRAME_TOGGLE_PERIOD + 4 * i, '0, i ? 32'h00FF_FFFF : 32'h0000_00FF);
		end
		bus(1'b0, 32'h8003_0100, '0, UNMAPPED_WORD);
		be <= 4'b0010;
		bus(1'b1, OFF_SUBSTITUTE_COLOR, '0, '0);
		be <= 4'hF;
		bus(1'b0, OFF_SUBSTITUTE_COLOR, '0, 32'h00FF_00FF);
		$display("registers done");
		bus(1'b1, OFF_FRAME_TOGGLE_PERIOD, 32'h0000_00FD, '0);
		for (i = 0; i < 2; i++) begin
			check(ph, 1'b0);
			frame();
		end
		check(ph, 1'b1);
		bus(1'b0, OFF_PIXEL_FORMAT_CONTROL, '0, 32'h0000_0100);
		$display("frame rate done");
		mk = PIX_W'($urandom());
		sb = PIX_W'($urandom());
		bus(1'b1, OFF_FRAME_TOGGLE_PERIOD, DATA_W'(RATE_FULL), '0);
		bus(1'b1, OFF_LUT_ADDRESS_MODIFIER, DATA_W'(mk), '0);
		bus(1'b1, OFF_SUBSTITUTE_COLOR, DATA_W'(sb), '0);
		bus(1'b1, OFF_COMPARE_BIT_EXCLUDE, '1, '0);
		stall <= 1'b1;
		foreach (modes[k]) begin
			bus(1'b1, OFF_PIXEL_FORMAT_CONTROL, DATA_W'({FMT_888, modes[k]}), '0);
			repeat (3) begin
				r = PIX_W'($urandom());
				pix(r, xf(modes[k], r));
			end
			pv <= 1'b0;
		end
		$display("modes done");
		bus(1'b1, OFF_PIXEL_FORMAT_CONTROL, DATA_W'({FMT_888, MODE_BKG}), '0);
		bus(1'b1, OFF_COMPARE_BIT_EXCLUDE, 32'h0000_0001, '0);
		bus(1'b1, OFF_BLINK_MATCH_VALUE, 32'h0000_0012, '0);
		bus(1'b1, OFF_LUT_ADDRESS_MODIFIER, 32'h0000_00FF, '0);
		pix(24'hAB_CD12, sb);
		pix(24'h77_7713, sb);
		pix(24'h00_0022, 24'h00_0022);
		pix(24'h12_3456, 24'h12_3456);
		pv <= 1'b0;
		$display("classify done");
		// Channel offsets in the packed formats: lanes saturate at their own width.
		bus(1'b1, OFF_COMPARE_BIT_EXCLUDE, '1, '0);
		bus(1'b1, OFF_SUBSTITUTE_COLOR, 32'h0000_8410, '0);
		bus(1'b1, OFF_PIXEL_FORMAT_CONTROL, DATA_W'({FMT_565, MODE_OFS_CHAN}), '0);
		pix(24'hAB_8410, 24'hAB_FFFF);
		pix(24'h00_0821, 24'h00_8C31);
		pv <= 1'b0;
		bus(1'b1, OFF_PIXEL_FORMAT_CONTROL, DATA_W'({FMT_555_MASK, MODE_OFS_CHAN}), '0);
		pix(24'h00_0421, 24'h00_0831);
		pv <= 1'b0;
		$display("colour formats done");
		bus(1'b1, OFF_PIXEL_FORMAT_CONTROL, DATA_W'({FMT_888, MODE_XOR}), '0);
		frame();
		check(ph, 1'b0);
		r = PIX_W'($urandom());
		pix(r, r);
		pix(~r, ~r);
		pv <= 1'b0;
		n = 0;
		while (pq.size() > 0 && n < 200) begin
			@(posedge clk);
			n++;
		end
		if (pq.size() > 0) hang();
		$display("pass-through done");
		results();
	end
endmodule
